// ===== verilog/ssirq_regs.svh
`ifndef SSIRQ_REGS_SVH
`define SSIRQ_REGS_SVH

// register offsets
`define SSIRQ_STATUS_OFS        8'h18
`define SSIRQ_CONFIG_OFS        8'h19

// fault_and_ready_flags field positions
`define SSIRQ_ST_SRC_HI         15
`define SSIRQ_ST_SRC_LO         14
`define SSIRQ_ST_UNDER          13
`define SSIRQ_ST_OVER           12
`define SSIRQ_ST_TIMEOUT        11
`define SSIRQ_ST_AMP_HIGH       10
`define SSIRQ_ST_AMP_LOW        9
`define SSIRQ_ST_ZERO           8
`define SSIRQ_ST_READY          6
`define SSIRQ_ST_UNREAD0        3

// fault_routing_config field positions
`define SSIRQ_CF_UNDER_RES      15
`define SSIRQ_CF_OVER_RES       14
`define SSIRQ_CF_TIMEOUT_RES    13
`define SSIRQ_CF_AMP_HIGH_RES   12
`define SSIRQ_CF_AMP_LOW_RES    11
`define SSIRQ_CF_UNDER_IRQ      7
`define SSIRQ_CF_OVER_IRQ       6
`define SSIRQ_CF_TIMEOUT_IRQ    5
`define SSIRQ_CF_AMP_HIGH_IRQ   4
`define SSIRQ_CF_AMP_LOW_IRQ    3
`define SSIRQ_CF_ZERO_IRQ       2
`define SSIRQ_CF_READY_IRQ      0

// reset values and writable bits
`define SSIRQ_STATUS_RST        16'h0000
`define SSIRQ_CONFIG_RST        16'h0000
`define SSIRQ_CONFIG_MASK       16'hF8FD

`endif

// ===== verilog/ssirq_pkg.sv
`default_nettype none
package ssirq_pkg;
    timeunit 1ns;
    timeprecision 1ns;

    // one bit per error kind, as raised by the error detectors
    typedef struct packed {
        logic under_range;
        logic over_range;
        logic timeout;
        logic amp_high;
        logic amp_low;
        logic zero_count;
    } ssirq_err_s;

    // one event from the conversion engine
    typedef struct packed {
        logic       valid;
        logic       conv;
        logic [1:0] chan;
        ssirq_err_s err;
    } ssirq_evt_s;

    // host register access strobe
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } ssirq_reg_req_s;

    // host read of a channel result register
    typedef struct packed {
        logic       rd;
        logic       upper;
        logic [1:0] chan;
    } ssirq_res_rd_s;

    // fault bits carried in a channel result register
    typedef struct packed {
        logic under_range;
        logic over_range;
        logic timeout;
        logic amp_fault;
    } ssirq_res_err_s;

    function automatic logic [3:0] ssirq_onehot(input logic [1:0] chan);
        ssirq_onehot = 4'h1 << chan;
    endfunction

endpackage
`default_nettype wire

// ===== verilog/ssirq_fault_mem.sv
`default_nettype none
module ssirq_fault_mem
    import ssirq_pkg::*;
#(
    parameter int DEPTH = 4,
    parameter int WIDTH = 4
) (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input  wire logic [WIDTH-1:0]         wr_data,
    input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output var  logic [WIDTH-1:0]         rd_data
);
    timeunit 1ns;
    timeprecision 1ns;

    if (DEPTH < 2 || WIDTH < 1) begin
        $error("ssirq_fault_mem: bad size");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0]            rd;
    } ssirq_mem_s;

    ssirq_mem_s st;
    ssirq_mem_s next_st;

    always_comb begin
        next_st = st;
        if (wr_en) begin
            next_st.mem[wr_addr] = wr_data;
        end
        next_st.rd = st.mem[rd_addr];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rd_data = st.rd;
endmodule
`default_nettype wire

// ===== verilog/ssirq_ready_track.sv
`default_nettype none
module ssirq_ready_track
    import ssirq_pkg::*;
#(
    parameter int NUM_CHAN = 4
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       conv_done,
    input  wire logic [1:0] conv_chan,
    input  wire logic       scan_enable,
    input  wire logic [3:0] scan_chan_mask,
    input  wire logic       res_rd,
    input  wire logic [1:0] res_rd_chan,
    output var  logic       ready_pulse,
    output var  logic [3:0] unread
);
    timeunit 1ns;
    timeprecision 1ns;

    if (NUM_CHAN < 2 || NUM_CHAN > 4) begin
        $error("ssirq_ready_track: NUM_CHAN 2..4");
    end

    typedef struct packed {
        logic [3:0] seen;
        logic [3:0] unread;
        logic       ready;
    } ssirq_trk_s;

    ssirq_trk_s st;
    ssirq_trk_s next_st;
    logic [3:0] chan_mask;

    assign chan_mask = scan_chan_mask & 4'((1 << NUM_CHAN) - 1);

    always_comb begin
        next_st       = st;
        next_st.ready = 1'b0;
        if (res_rd) begin
            next_st.unread = next_st.unread & ~ssirq_onehot(res_rd_chan);
        end
        if (conv_done) begin
            next_st.unread = next_st.unread | ssirq_onehot(conv_chan);
            if (!scan_enable) begin
                next_st.ready = 1'b1;
                next_st.seen  = 4'h0;
            end else if (((st.seen | ssirq_onehot(conv_chan)) & chan_mask) == chan_mask) begin
                next_st.ready = 1'b1;
                next_st.seen  = 4'h0;
            end else begin
                next_st.seen  = st.seen | ssirq_onehot(conv_chan);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign ready_pulse = st.ready;
    assign unread      = st.unread;
endmodule
`default_nettype wire

// ===== verilog/ssirq_top.sv
// Functional notes
// - status 15:14 give faulting channel index
// - errors latched until status or source-upper read
// - bit 13 flags under-range since last read
// - bit 12 flags over-range since last read
// - bit 11 flags timeout since last read
// - bit 10 flags amplitude-high since last read
// - bit 9 flags amplitude-low since last read
// - bit 8 flags zero-count since last read
// - bit 6 flags fresh results ready
// - bits 3..0 flag unread results channels 0..3
// - config 15 routes under-range to result
// - config 14 routes over-range to result
// - config 13 routes timeout to result
// - config 12/11 route amplitude to result
// - config 7 routes under-range to pin/status
// - config 6 routes over-range to pin/status
// - config 5 routes timeout to pin/status
// - config 4/3 route amplitude to pin/status
// - config 2 routes zero-count to pin/status
// - config 0 routes result-ready to pin/status
// - suppress control blocks interrupt pin assertion
// - scan enable picks single or sequential mode
`include "ssirq_regs.svh"
`default_nettype none
module ssirq_top
    import ssirq_pkg::*;
#(
    parameter int NUM_CHAN = 4
) (
    input  wire logic           clk,
    input  wire logic           rst,
    input  wire ssirq_reg_req_s reg_req,
    output var  logic [15:0]    reg_rdata,
    input  wire ssirq_evt_s     evt,
    input  wire ssirq_res_rd_s  res_rd,
    input  wire logic           irq_suppress,
    input  wire logic           scan_enable,
    input  wire logic [3:0]     scan_chan_mask,
    output var  ssirq_res_err_s result_fault,
    output var  logic           irq_n_pin
);
    timeunit 1ns;
    timeprecision 1ns;

    if (NUM_CHAN < 2 || NUM_CHAN > 4) begin
        $error("ssirq_top: NUM_CHAN 2..4");
    end

    typedef struct packed {
        logic [15:0] config_word;
        logic [1:0]  source_chan;
        ssirq_err_s  flags;
        logic        ready;
        logic [15:0] rdata;
        logic        irq_n;
    } ssirq_top_s;

    ssirq_top_s     st;
    ssirq_top_s     next_st;
    ssirq_err_s     routed;
    ssirq_res_err_s to_result;
    logic [3:0]     unread;
    logic           ready_pulse;
    logic           status_rd;
    logic           source_upper_rd;
    logic [15:0]    status_word;

    // error kinds reported to pin and status
    always_comb begin
        routed            = '0;
        if (evt.valid) begin
            routed.under_range = evt.err.under_range
                               & st.config_word[`SSIRQ_CF_UNDER_IRQ];
            routed.over_range  = evt.err.over_range
                               & st.config_word[`SSIRQ_CF_OVER_IRQ];
            routed.timeout     = evt.err.timeout
                               & st.config_word[`SSIRQ_CF_TIMEOUT_IRQ];
            routed.amp_high    = evt.err.amp_high
                               & st.config_word[`SSIRQ_CF_AMP_HIGH_IRQ];
            routed.amp_low     = evt.err.amp_low
                               & st.config_word[`SSIRQ_CF_AMP_LOW_IRQ];
            routed.zero_count  = evt.err.zero_count
                               & st.config_word[`SSIRQ_CF_ZERO_IRQ];
        end
    end

    // error kinds reported in the channel result word
    always_comb begin
        to_result             = '0;
        to_result.under_range = evt.err.under_range
                              & st.config_word[`SSIRQ_CF_UNDER_RES];
        to_result.over_range  = evt.err.over_range
                              & st.config_word[`SSIRQ_CF_OVER_RES];
        to_result.timeout     = evt.err.timeout
                              & st.config_word[`SSIRQ_CF_TIMEOUT_RES];
        to_result.amp_fault   = (evt.err.amp_high
                                 & st.config_word[`SSIRQ_CF_AMP_HIGH_RES])
                              | (evt.err.amp_low
                                 & st.config_word[`SSIRQ_CF_AMP_LOW_RES]);
    end

    // status word image
    always_comb begin
        status_word                                        = `SSIRQ_STATUS_RST;
        status_word[`SSIRQ_ST_SRC_HI:`SSIRQ_ST_SRC_LO]     = st.source_chan;
        status_word[`SSIRQ_ST_UNDER]                       = st.flags.under_range;
        status_word[`SSIRQ_ST_OVER]                        = st.flags.over_range;
        status_word[`SSIRQ_ST_TIMEOUT]                     = st.flags.timeout;
        status_word[`SSIRQ_ST_AMP_HIGH]                    = st.flags.amp_high;
        status_word[`SSIRQ_ST_AMP_LOW]                     = st.flags.amp_low;
        status_word[`SSIRQ_ST_ZERO]                        = st.flags.zero_count;
        status_word[`SSIRQ_ST_READY]                       = st.ready;
        status_word[`SSIRQ_ST_UNREAD0-:4]                  = {unread[0], unread[1],
                                                              unread[2], unread[3]};
    end

    assign status_rd       = reg_req.rd && (reg_req.addr == `SSIRQ_STATUS_OFS);
    assign source_upper_rd = res_rd.rd && res_rd.upper && (res_rd.chan == st.source_chan);

    always_comb begin
        next_st = st;
        // register reads, unmapped offsets read zero
        if (reg_req.rd) begin
            case (reg_req.addr)
                `SSIRQ_STATUS_OFS: next_st.rdata = status_word;
                `SSIRQ_CONFIG_OFS: next_st.rdata = st.config_word;
                default:           next_st.rdata = 16'h0000;
            endcase
        end
        if (reg_req.wr && reg_req.addr == `SSIRQ_CONFIG_OFS) begin
            next_st.config_word = reg_req.wdata & `SSIRQ_CONFIG_MASK;
        end
        // clears first, so a new event in the same cycle wins
        if (status_rd || source_upper_rd) begin
            next_st.flags = '0;
        end
        if (status_rd) begin
            next_st.ready = 1'b0;
        end
        if (routed != '0) begin
            next_st.flags       = next_st.flags | routed;
            next_st.source_chan = evt.chan;
        end
        if (ready_pulse && st.config_word[`SSIRQ_CF_READY_IRQ]) begin
            next_st.ready = 1'b1;
        end
        // pin low while any latched flag stands and not suppressed
        next_st.irq_n = !((next_st.flags != '0 || next_st.ready) && !irq_suppress);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st             <= '0;
            st.config_word <= `SSIRQ_CONFIG_RST;
            st.irq_n       <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    ssirq_ready_track #(
        .NUM_CHAN (NUM_CHAN)
    ) u_track (
        .clk            (clk),
        .rst            (rst),
        .conv_done      (evt.valid && evt.conv),
        .conv_chan      (evt.chan),
        .scan_enable    (scan_enable),
        .scan_chan_mask (scan_chan_mask),
        .res_rd         (res_rd.rd),
        .res_rd_chan    (res_rd.chan),
        .ready_pulse    (ready_pulse),
        .unread         (unread)
    );

    ssirq_fault_mem #(
        .DEPTH (4),
        .WIDTH (4)
    ) u_mem (
        .clk     (clk),
        .rst     (rst),
        .wr_en   (evt.valid),
        .wr_addr (evt.chan),
        .wr_data (to_result),
        .rd_addr (res_rd.chan),
        .rd_data (result_fault)
    );

    assign reg_rdata = st.rdata;
    assign irq_n_pin = st.irq_n;
endmodule
`default_nettype wire

// ===== verification/ssirq_monitor.sv
`default_nettype none
module ssirq_monitor
    import ssirq_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           rst,
    input  wire ssirq_reg_req_s reg_req,
    input  wire logic [15:0]    reg_rdata,
    input  wire ssirq_evt_s     evt,
    input  wire ssirq_res_rd_s  res_rd,
    input  wire logic           irq_suppress,
    input  wire logic           scan_enable,
    input  wire logic [3:0]     scan_chan_mask,
    input  wire ssirq_res_err_s result_fault,
    input  wire logic           irq_n_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] cfg;
    logic [5:0]  routed;
    logic [3:0]  exp_rf;
    logic        st_rd;

    // shadow of the routing word
    always_ff @(posedge clk) begin
        if (rst)
            cfg <= 16'h0000;
        else if (reg_req.wr && reg_req.addr == 8'h19)
            cfg <= reg_req.wdata & 16'hF8FD;
    end
    assign routed = evt.err & cfg[7:2];
    assign exp_rf = {evt.err.under_range & cfg[15], evt.err.over_range & cfg[14],
        evt.err.timeout & cfg[13], (evt.err.amp_high & cfg[12]) | (evt.err.amp_low & cfg[11])};
    assign st_rd = reg_req.rd && reg_req.addr == 8'h18 && !evt.valid && !res_rd.rd;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_err; evt.valid && |routed; endsequence
    sequence s_st; st_rd; endsequence

    property p_rst; disable iff (1'b0)
        rst |=> irq_n_pin && reg_rdata == 16'h0000 && result_fault == 4'h0; endproperty
    property p_irq; evt.valid && |routed && !irq_suppress |=> !irq_n_pin; endproperty
    property p_supp; irq_suppress [*2] |-> irq_n_pin; endproperty
    property p_cfg; reg_req.rd && !reg_req.wr && reg_req.addr == 8'h19
        |=> reg_rdata == $past(cfg); endproperty
    property p_clear; s_st ##1 s_st |=> reg_rdata[13:8] == 6'h00; endproperty
    property p_src; s_err ##1 s_st |=> reg_rdata[15:14] == $past(evt.chan, 2); endproperty
    property p_flags; s_err ##1 s_st
        |=> (reg_rdata[13:8] & $past(routed, 2)) == $past(routed, 2); endproperty
    property p_rf; evt.valid ##1 (!evt.valid && res_rd.chan == $past(evt.chan))
        |=> result_fault == $past(exp_rf, 2); endproperty

    a_rst: assert property (p_rst) else $error("bad reset outputs");
    a_irq: assert property (p_irq) else $error("pin not asserted");
    a_supp: assert property (p_supp) else $error("pin not suppressed");
    a_cfg: assert property (p_cfg) else $error("config readback");
    a_clear: assert property (p_clear) else $error("flags not cleared");
    a_src: assert property (p_src) else $error("wrong source channel");
    a_flags: assert property (p_flags) else $error("flag missing");
    a_rf: assert property (p_rf) else $error("result fault");
endmodule
bind ssirq_top ssirq_monitor u_ssirq_monitor (.clk(clk), .rst(rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .evt(evt), .res_rd(res_rd), .irq_suppress(irq_suppress),
    .scan_enable(scan_enable), .scan_chan_mask(scan_chan_mask),
    .result_fault(result_fault), .irq_n_pin(irq_n_pin));
`default_nettype wire

// ===== verification/ssirq_host_model.sv
`default_nettype none
module ssirq_host_model
    import ssirq_pkg::*;
(
    input  wire logic           clk,
    output var  ssirq_reg_req_s reg_req,
    output var  ssirq_res_rd_s  res_rd
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        reg_req = '0;
        res_rd = '0;
    end
    // n beats of one register access
    task automatic reg_op(input logic wr, input logic [7:0] a, input logic [15:0] d, input int n);
        @(posedge clk);
        reg_req <= '{rd: !wr, wr: wr, addr: a, wdata: d & 16'hFFFD};
        repeat (n) @(posedge clk);
        reg_req.rd <= 1'b0;
        reg_req.wr <= 1'b0;
    endtask
    task automatic res_op(input logic up, input logic [1:0] c);
        @(posedge clk);
        res_rd <= '{rd: 1'b1, upper: up, chan: c};
        @(posedge clk);
        res_rd.rd <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== verification/tb.sv
`default_nettype none
module tb
    import ssirq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic           clk;
    logic           rst;
    logic           supp;
    logic           scan;
    logic [3:0]     mask;
    ssirq_evt_s     evt;
    ssirq_reg_req_s req;
    ssirq_res_rd_s  rrd;
    logic [15:0]    rdata;
    ssirq_res_err_s rfo;
    logic           irq_n;
    int             seed = 93;
    int             mismatches = 0;
    int             checks = 0;
    int             cycles = 0;
    logic [15:0]    cfg;
    logic [5:0]     flags;
    logic [1:0]     src;
    logic           rdy;
    logic [3:0]     unread;
    logic [3:0]     seen;
    logic [3:0]     rf [4];

    ssirq_top u_ssirq_top (.clk(clk), .rst(rst), .reg_req(req), .reg_rdata(rdata), .evt(evt),
        .res_rd(rrd), .irq_suppress(supp), .scan_enable(scan), .scan_chan_mask(mask),
        .result_fault(rfo), .irq_n_pin(irq_n));
    ssirq_host_model host (.clk(clk), .reg_req(req), .res_rd(rrd));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    function automatic logic [15:0] stat();
        return {src, flags, 1'b0, rdy, 2'b00, unread[0], unread[1], unread[2], unread[3]};
    endfunction
    task automatic settle();
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        host.reg_op(1'b0, a, 16'h0000, 1);
        settle();
        chk(rdata, e);
    endtask
    task automatic wcfg(input logic [15:0] d);
        host.reg_op(1'b1, 8'h19, d, 1);
        cfg = d & 16'hF8FD;
        settle();
    endtask
    task automatic fire(input logic [1:0] c, input logic cv, input logic [5:0] e);
        @(posedge clk);
        evt <= '{valid: 1'b1, conv: cv, chan: c, err: e};
        @(posedge clk);
        evt.valid <= 1'b0;
        flags |= e & cfg[7:2];
        if ((e & cfg[7:2]) != 6'h00)
            src = c;
        rf[c] = {e[5] & cfg[15], e[4] & cfg[14], e[3] & cfg[13],
                 (e[2] & cfg[12]) | (e[1] & cfg[11])};
        if (cv) begin
            unread[c] = 1'b1;
            seen[c] = 1'b1;
            if (!scan || (seen & mask) == mask) begin
                rdy |= cfg[0];
                seen = 4'h0;
            end
        end
        settle();
    endtask
    task automatic do_reset(input logic s);
        @(posedge clk);
        rst <= 1'b1;
        scan <= s;
        mask <= s ? 4'hB : 4'h5;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        {cfg, flags, src, rdy, unread, seen} = '0;
        for (int i = 0; i < 4; i++)
            rf[i] = 4'h0;
        rd(8'h18, 16'h0000);
        rd(8'h19, 16'h0000);
    endtask
    // event and two adjacent status reads
    task automatic burst();
        wcfg(16'hF8FD);
        @(posedge clk);
        evt <= '{valid: 1'b1, conv: 1'b0, chan: 2'h2, err: 6'h3F};
        fork
            host.reg_op(1'b0, 8'h18, 16'h0000, 2);
            begin
                @(posedge clk);
                evt.valid <= 1'b0;
            end
        join
        settle();
        {src, flags, rdy} = {2'h2, 6'h00, 1'b0};
        rf[2] = 4'hF;
        chk(rdata, stat());
    endtask
    task automatic run(input int n);
        int r;
        for (int i = 0; i < n; i++) begin
            r = $random(seed);
            case (r[2:0])
                3'h0, 3'h1, 3'h2: fire(r[9:8], r[10], r[16:11]);
                3'h3: begin
                    rd(8'h18, stat());
                    flags = 6'h00;
                    rdy = 1'b0;
                end
                3'h4: begin
                    host.res_op(r[12], r[9:8]);
                    settle();
                    chk({12'h000, rfo}, {12'h000, rf[r[9:8]]});
                    unread[r[9:8]] = 1'b0;
                    if (r[12] && r[9:8] == src)
                        flags = 6'h00;
                end
                3'h5: wcfg(r[31:16]);
                3'h6: rd(8'h19, cfg);
                default: begin
                    @(posedge clk);
                    supp <= r[8];
                    rd(8'h20 | r[31:24], 16'h0000);
                end
            endcase
            chk({15'h0000, irq_n}, {15'h0000, !((|flags || rdy) && !supp)});
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            mismatches++;
            end_sim();
        end
    end
    initial begin
        {rst, supp, scan, mask, evt} = {1'b1, 1'b0, 1'b0, 4'h5, 10'h000};
        for (int ph = 0; ph < 2; ph++) begin
            do_reset(ph[0]);
            burst();
            run(250);
            $display("phase %0d done", ph);
        end
        end_sim();
    end
endmodule
`default_nettype wire
